/* cap_pin_src.sv */
// Purpose: model of the signal source on the two capture pins
// Assumes: levels change just after a clock edge
// Notes:   each level is held past the three-flop filter
`timescale 1ns/100ps
module cap_pin_src (
    // clock
    input  wire logic       clock_in,
    // pins toward the block
    output logic      [1:0] pin_out
);
    initial pin_out = 2'b00;
    // change one pin, then hold it eight cycles
    task automatic set_level(input int ch, input logic v);
        @(posedge clock_in);
        pin_out[ch] <= v;
        repeat (8) @(posedge clock_in);
    endtask
endmodule

/* capture_ctrl.v */
// Purpose: capture control for input channels 0 and 1 of one pwm group
// Assumes: apb slave, one clock, counter supplied by the pwm timer
// Notes:   density variant and clear select held in a mode register
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "capture_map.vh"

// Notes on behaviour
// RL1 - enabled channel latches counter on rising and falling edges into latches
// RL2 - disabled channel keeps latches and raises no capture interrupt
// RL3 - channel 1 falling interrupt enable gates falling-edge interrupts
// RL4 - channel 1 rising interrupt enable gates rising-edge interrupts
// RL5 - channel 1 invert bit inverts pin before edge detection
// RL6 - channel 0 falling latch sets its falling-latched indicator
// RL7 - channel 0 rising latch sets its rising-latched indicator
// RL8 - medium density: writing 0 clears a latched indicator
// RL9 - low density: write 0 or 1 clears, chosen by clear select
// RL10 - channel 0 flag set by rising or falling edge per enables
// RL11 - writing 1 clears a capture interrupt flag, 0 leaves it
// RL12 - channel 1 enable gives channel 1 the same capture behaviour
// RL13 - inputs synchronised; reserved bits read zero, writes ignored
module capture_ctrl #(
    parameter CNT_W = 16
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             sys_rst_in,
    // apb slave
    input  wire             psel_in,
    input  wire             penable_in,
    input  wire             pwrite_in,
    input  wire [11:0]      paddr_in,
    input  wire [31:0]      pwdata_in,
    output reg  [31:0]      prdata_out,
    output reg              pready_out,
    output reg              pslverr_out,
    // capture pins and counter
    input  wire [1:0]       cap_pin_in,
    input  wire [CNT_W-1:0] pwm_count_in,
    // interrupt
    output reg              irq_out
);
    reg  [31:0]      ctrl_reg;
    reg  [31:0]      ctrl_next;
    reg  [CNT_W-1:0] rise_latch_reg [0:1];
    reg  [CNT_W-1:0] fall_latch_reg [0:1];
    reg  [3:0]       irq_stat_reg;
    reg  [3:0]       irq_stat_next;
    reg  [3:0]       irq_mask_reg;
    reg  [1:0]       mode_reg;
    reg  [31:0]      rdata_next;
    reg              err_next;
    wire [1:0]       rise_evt;
    wire [1:0]       fall_evt;
    wire             wr_en;
    wire             rd_en;
    wire             low_density;
    wire             clr_sel;
    integer          ch;
    integer          base;

    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `CAP_CTRL_OFS) || (a == `CAP_RISE0_OFS) ||
                         (a == `CAP_FALL0_OFS) || (a == `CAP_RISE1_OFS) ||
                         (a == `CAP_FALL1_OFS) || (a == `CAP_IRQ_STAT_OFS) ||
                         (a == `CAP_IRQ_MASK_OFS) || (a == `CAP_MODE_OFS);
        end
    endfunction

    // clear test for a latched indicator given the written bit
    function flag_clears;
        input wbit;
        input low_dens;
        input sel;
        begin
            if (low_dens)
                flag_clears = sel ? wbit : ~wbit; // [RL9]
            else
                flag_clears = ~wbit; // [RL8]
        end
    endfunction

    assign wr_en       = psel_in & penable_in & pwrite_in & pready_out;
    assign rd_en       = psel_in & penable_in & ~pwrite_in & pready_out;
    assign low_density = mode_reg[`CAP_MODE_LOWDENS_BIT];
    assign clr_sel     = mode_reg[`CAP_MODE_CLRSEL_BIT];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            capture_edge_detect edge_u (
                .clock_in   (clock_in),
                .sys_rst_in (sys_rst_in),
                .pin_in     (cap_pin_in[g]),
                .invert_in  (ctrl_reg[g*`CAP_CH_STRIDE + `CAP_INV_BIT]), // [RL5]
                .rise_out   (rise_evt[g]),
                .fall_out   (fall_evt[g])
            );

            always @(posedge clock_in) begin
                if (sys_rst_in) begin
                    rise_latch_reg[g] <= {CNT_W{1'b0}};
                    fall_latch_reg[g] <= {CNT_W{1'b0}};
                end else if (ctrl_reg[g*`CAP_CH_STRIDE + `CAP_EN_BIT]) begin // [RL2] [RL12]
                    if (rise_evt[g])
                        rise_latch_reg[g] <= pwm_count_in; // [RL1]
                    if (fall_evt[g])
                        fall_latch_reg[g] <= pwm_count_in; // [RL1]
                end
            end
        end
    endgenerate

    // control register: software write, then hardware set wins
    always @* begin
        ctrl_next     = ctrl_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_en && paddr_in == `CAP_CTRL_OFS) begin
            ctrl_next = (ctrl_reg & ~`CAP_CTRL_WMASK) |
                        (pwdata_in & `CAP_CTRL_WMASK); // [RL13]
        end
        for (ch = 0; ch < 2; ch = ch + 1) begin
            base = ch * `CAP_CH_STRIDE;
            if (wr_en && paddr_in == `CAP_CTRL_OFS) begin
                if (pwdata_in[base + `CAP_IRQ_FLAG_BIT])
                    ctrl_next[base + `CAP_IRQ_FLAG_BIT] = 1'b0; // [RL11]
                if (flag_clears(pwdata_in[base + `CAP_RISE_FLAG_BIT],
                                low_density, clr_sel))
                    ctrl_next[base + `CAP_RISE_FLAG_BIT] = 1'b0;
                if (flag_clears(pwdata_in[base + `CAP_FALL_FLAG_BIT],
                                low_density, clr_sel))
                    ctrl_next[base + `CAP_FALL_FLAG_BIT] = 1'b0;
            end
            if (ctrl_reg[base + `CAP_EN_BIT]) begin // [RL2] [RL12]
                if (rise_evt[ch]) begin
                    ctrl_next[base + `CAP_RISE_FLAG_BIT] = 1'b1; // [RL7]
                    irq_stat_next[ch*2] = 1'b1;
                    if (ctrl_reg[base + `CAP_RISE_IE_BIT])
                        ctrl_next[base + `CAP_IRQ_FLAG_BIT] = 1'b1; // [RL4] [RL10]
                end
                if (fall_evt[ch]) begin
                    ctrl_next[base + `CAP_FALL_FLAG_BIT] = 1'b1; // [RL6]
                    irq_stat_next[ch*2+1] = 1'b1;
                    if (ctrl_reg[base + `CAP_FALL_IE_BIT])
                        ctrl_next[base + `CAP_IRQ_FLAG_BIT] = 1'b1; // [RL3] [RL10]
                end
            end
        end
        if (rd_en && paddr_in == `CAP_IRQ_STAT_OFS) begin
            irq_stat_next = 4'h0;
            for (ch = 0; ch < 2; ch = ch + 1) begin
                if (ctrl_reg[ch*`CAP_CH_STRIDE + `CAP_EN_BIT]) begin
                    if (rise_evt[ch])
                        irq_stat_next[ch*2] = 1'b1;
                    if (fall_evt[ch])
                        irq_stat_next[ch*2+1] = 1'b1;
                end
            end
        end
    end

    // read mux
    always @* begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        case (paddr_in)
            `CAP_CTRL_OFS:     rdata_next = ctrl_reg;
            `CAP_RISE0_OFS:    rdata_next[CNT_W-1:0] = rise_latch_reg[0];
            `CAP_FALL0_OFS:    rdata_next[CNT_W-1:0] = fall_latch_reg[0];
            `CAP_RISE1_OFS:    rdata_next[CNT_W-1:0] = rise_latch_reg[1];
            `CAP_FALL1_OFS:    rdata_next[CNT_W-1:0] = fall_latch_reg[1];
            `CAP_IRQ_STAT_OFS: rdata_next[3:0] = irq_stat_reg;
            `CAP_IRQ_MASK_OFS: rdata_next[3:0] = irq_mask_reg;
            `CAP_MODE_OFS:     rdata_next[1:0] = mode_reg;
            default:           err_next = 1'b1;
        endcase
    end

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_reg     <= `CAP_CTRL_RESET;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            mode_reg     <= 2'h0;
            prdata_out   <= 32'h0000_0000;
            pready_out   <= 1'b0;
            pslverr_out  <= 1'b0;
            irq_out      <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_out      <= |(irq_stat_next & irq_mask_reg);
            if (wr_en && paddr_in == `CAP_IRQ_MASK_OFS)
                irq_mask_reg <= pwdata_in[3:0];
            if (wr_en && paddr_in == `CAP_MODE_OFS)
                mode_reg <= pwdata_in[1:0];
            // one wait state: ready in the cycle after penable rises
            pready_out <= psel_in & penable_in & ~pready_out;
            if (psel_in & penable_in & ~pready_out) begin
                prdata_out  <= pwrite_in ? 32'h0000_0000 : rdata_next;
                pslverr_out <= err_next | ~known_addr(paddr_in);
            end else begin
                pslverr_out <= 1'b0;
            end
        end
    end
endmodule

/* capture_ctrl_monitor.sv */
// Purpose: port checks for the capture control block
// Assumes: apb master holds each request until pready
// Notes:   enable bits shadowed from control writes
`timescale 1ns/100ps
`include "capture_map.vh"
module capture_ctrl_chk (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // apb
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        pslverr_out,
    // interrupt
    input  wire logic        irq_out
);
    logic [1:0] en_reg;
    wire        ctl = paddr_in == `CAP_CTRL_OFS;
    wire        mapped = paddr_in inside {`CAP_CTRL_OFS, `CAP_RISE0_OFS, `CAP_FALL0_OFS,
        `CAP_RISE1_OFS, `CAP_FALL1_OFS, `CAP_IRQ_STAT_OFS, `CAP_IRQ_MASK_OFS, `CAP_MODE_OFS};
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            en_reg <= 2'b00;
        end else if (psel_in && penable_in && pwrite_in && pready_out && ctl) begin
            en_reg <= {pwdata_in[19], pwdata_in[3]};
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_answer;
        psel_in && penable_in ##1 pready_out;
    endsequence
    property p_ready;
        s_setup |=> s_answer;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not two edges after setup");
    property p_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err;
        pslverr_out |-> pready_out;
    endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_unmap;
        pready_out && !pwrite_in && !mapped |-> pslverr_out && prdata_out == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    property p_map;
        pready_out && mapped |-> !pslverr_out;
    endproperty
    a_map: assert property (p_map) else $error("mapped access refused");
    property p_resv;
        pready_out && !pwrite_in && ctl |-> (prdata_out & 32'hff20_ff20) == 32'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bits not zero");
    property p_quiet;
        en_reg == 2'b00 && !irq_out && !psel_in && !pready_out |=> !irq_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt with capture off");
    property p_rst;
        disable iff (1'b0) sys_rst_in |=> !irq_out && !pready_out && !pslverr_out;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not low in reset");
endmodule
bind capture_ctrl capture_ctrl_chk capture_ctrl_chk_i (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .irq_out(irq_out));

/* capture_ctrl_tb.sv */
// Purpose: register-level test of the capture control block
// Assumes: counter held still across each capture
// Notes:   apb master waits for pready with a bound
`timescale 1ns/100ps
`include "capture_map.vh"
module capture_ctrl_tb;
    logic        clock_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic [15:0] cnt = 16'h0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         irq;
    wire  [1:0]  pins;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    always #20 clock_in = ~clock_in;
    cap_pin_src cap_pin_src_i (.clock_in(clock_in), .pin_out(pins));
    capture_ctrl #(.CNT_W(16)) capture_ctrl_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
        .cap_pin_in(pins), .pwm_count_in(cnt), .irq_out(irq));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string name);
        xfer(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rc(`CAP_CTRL_OFS, 32'h0, "ctrl reset");
        rc(12'h0fc, 32'h0, "unmapped");
        xfer(1'b1, `CAP_CTRL_OFS, 32'hfff6_fff6);
        rc(`CAP_CTRL_OFS, 32'h0006_0006, "ctrl writable");
        xfer(1'b1, `CAP_IRQ_MASK_OFS, 32'hf);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0000_000e);
        $display("test registers done");
        cnt <= 16'h1234;
        cap_pin_src_i.set_level(0, 1'b1);
        check("irq", {31'h0, irq}, 32'h1);
        rc(`CAP_RISE0_OFS, 32'h1234, "rise0");
        rc(`CAP_CTRL_OFS, 32'h0000_005e, "ctrl rise0");
        rc(`CAP_IRQ_STAT_OFS, 32'h1, "status");
        repeat (2) @(posedge clock_in);
        check("irq clear", {31'h0, irq}, 32'h0);
        cnt <= 16'h0abc;
        cap_pin_src_i.set_level(0, 1'b0);
        rc(`CAP_FALL0_OFS, 32'h0abc, "fall0");
        rc(`CAP_CTRL_OFS, 32'h0000_00de, "ctrl fall0");
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0000_00ce);
        rc(`CAP_CTRL_OFS, 32'h0000_00de, "flags kept");
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0000_001e);
        rc(`CAP_CTRL_OFS, 32'h0000_000e, "flags clear");
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0000_0006);
        rc(`CAP_IRQ_STAT_OFS, 32'h2, "status fall");
        cnt <= 16'h5555;
        cap_pin_src_i.set_level(0, 1'b1);
        rc(`CAP_RISE0_OFS, 32'h1234, "rise0 held");
        rc(`CAP_CTRL_OFS, 32'h0000_0006, "ctrl off");
        check("irq off", {31'h0, irq}, 32'h0);
        $display("test channel zero done");
        xfer(1'b1, `CAP_IRQ_MASK_OFS, 32'h0);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h000a_0000);
        cnt <= 16'h2222;
        cap_pin_src_i.set_level(1, 1'b1);
        check("irq masked", {31'h0, irq}, 32'h0);
        rc(`CAP_RISE1_OFS, 32'h2222, "rise1");
        rc(`CAP_CTRL_OFS, 32'h005a_0000, "ctrl rise1");
        xfer(1'b1, `CAP_CTRL_OFS, 32'h001a_0000);
        cnt <= 16'h3333;
        cap_pin_src_i.set_level(1, 1'b0);
        rc(`CAP_FALL1_OFS, 32'h3333, "fall1");
        rc(`CAP_CTRL_OFS, 32'h008a_0000, "ctrl fall1");
        cnt <= 16'h4444;
        xfer(1'b1, `CAP_CTRL_OFS, 32'h000b_0000);
        repeat (8) @(posedge clock_in);
        rc(`CAP_RISE1_OFS, 32'h4444, "rise1 inv");
        rc(`CAP_CTRL_OFS, 32'h005b_0000, "ctrl inv");
        xfer(1'b1, `CAP_CTRL_OFS, 32'h001d_0000);
        cnt <= 16'h6666;
        cap_pin_src_i.set_level(1, 1'b1);
        rc(`CAP_FALL1_OFS, 32'h6666, "fall1 inv");
        rc(`CAP_CTRL_OFS, 32'h009d_0000, "ctrl fall ie");
        $display("test channel one done");
        xfer(1'b1, `CAP_MODE_OFS, 32'h1);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0089_0000);
        rc(`CAP_CTRL_OFS, 32'h0099_0000, "low sel0");
        xfer(1'b1, `CAP_MODE_OFS, 32'h3);
        xfer(1'b1, `CAP_CTRL_OFS, 32'h0089_0000);
        rc(`CAP_CTRL_OFS, 32'h0019_0000, "low sel1");
        $display("test low density done");
        test_done();
    end
endmodule

/* capture_edge_detect.v */
// Purpose: synchronise one capture pin and report its edges
// Assumes: pin is asynchronous to clock_in
// Notes:   three flops; a change counts when the last two agree
`timescale 1ns/100ps
module capture_edge_detect (
    // clock and reset
    input  wire clock_in,
    input  wire sys_rst_in,
    // pin and control
    input  wire pin_in,
    input  wire invert_in,
    // edge pulses
    output reg  rise_out,
    output reg  fall_out
);
    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg level_reg;
    wire agreed_level;
    wire seen_level;

    assign agreed_level = sync2_reg;
    // inversion before edge detection [RL5]
    assign seen_level   = agreed_level ^ invert_in;

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            sync1_reg <= pin_in; // [RL13]
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
            if (sync2_reg == sync3_reg) begin
                level_reg <= seen_level;
                rise_out  <= seen_level & ~level_reg;
                fall_out  <= ~seen_level & level_reg;
            end
        end
    end
endmodule

/* capture_map.vh */
// Purpose: constants for the two-channel capture control block
// Assumes: apb byte addresses, 32-bit data
// Notes:   register offsets other than the control register are local choices
`ifndef CAPTURE_MAP_VH
`define CAPTURE_MAP_VH

`define CAP_CTRL_OFS        12'h050
`define CAP_RISE0_OFS       12'h058
`define CAP_FALL0_OFS       12'h05c
`define CAP_RISE1_OFS       12'h060
`define CAP_FALL1_OFS       12'h064
`define CAP_IRQ_STAT_OFS    12'h068
`define CAP_IRQ_MASK_OFS    12'h06c
`define CAP_MODE_OFS        12'h070

`define CAP_CTRL_RESET      32'h0000_0000
`define CAP_CTRL_WMASK      32'h000f_000f

// per-channel field positions, channel 1 adds 16
`define CAP_INV_BIT         0
`define CAP_RISE_IE_BIT     1
`define CAP_FALL_IE_BIT     2
`define CAP_EN_BIT          3
`define CAP_IRQ_FLAG_BIT    4
`define CAP_RISE_FLAG_BIT   6
`define CAP_FALL_FLAG_BIT   7
`define CAP_CH_STRIDE       16

// mode register fields
`define CAP_MODE_LOWDENS_BIT 0
`define CAP_MODE_CLRSEL_BIT  1

`endif
